/* core/oodt_map.svh */
// Offsets, fields, resets and timing counts of the on/off delay timer.
// Assumes a 20 MHz clock and a byte-addressed Avalon-MM register port.
//
// What this block does
// - On-delay: trigger rise starts elapsed from zero
// - On-delay: output high after delay held high
// - On-delay: early trigger fall clears elapsed, output low
// - On-delay: output low while trigger low
// - Delay from constant or selected block value
// - Constant bases: s 10ms, m 1s, h 1min
// - Block value limits 99990 ms, 5999 s/min
// - Off-delay: trigger rise sets output at once
// - Off-delay: trigger fall restarts elapsed, output held
// - Off-delay: output low when elapsed reaches delay
// - Off-delay: new trigger pulse restarts elapsed
// - Off-delay: clear zeroes elapsed, output low
// - Off-delay: clear beats trigger
// - Retention keeps state over power loss
`ifndef OODT_MAP_SVH
`define OODT_MAP_SVH

`define OODT_CLK_PERIOD_NS   50
`define OODT_TICK_FINE_NS    10000000
`define OODT_CYC_FINE        (`OODT_TICK_FINE_NS / `OODT_CLK_PERIOD_NS)
`define OODT_FINE_PER_SEC    100
`define OODT_SEC_PER_MIN     60
`define OODT_MS_PER_FINE     10

`define OODT_CTRL_OFS        5'h00
`define OODT_DELAY_OFS       5'h04
`define OODT_STATUS_OFS      5'h08
`define OODT_ELAPSED_OFS     5'h0c

`define OODT_CTRL_MODE_BIT   0
`define OODT_CTRL_TB_LSB     1
`define OODT_CTRL_SRC_BIT    3
`define OODT_CTRL_RET_BIT    4
`define OODT_CTRL_BLK_LSB    8
`define OODT_CTRL_MASK       32'h00000f1f
`define OODT_CTRL_RST        32'h00000000

`define OODT_DLY_MIN_LSB     0
`define OODT_DLY_MAJ_LSB     8
`define OODT_DLY_MASK        32'h00007f7f
`define OODT_DLY_RST         32'h00000000

`define OODT_STAT_Q_BIT      0
`define OODT_STAT_TRG_BIT    1
`define OODT_STAT_RUN_BIT    2
`define OODT_STAT_DLY_LSB    16

`define OODT_MAX_MAJOR       7'h63
`define OODT_MAX_MINOR_FINE  7'h63
`define OODT_MAX_MINOR_60    7'h3b
`define OODT_MAX_SRC_MS      99990
`define OODT_MAX_SRC_UNIT    5999

`endif

/* core/oodt_pkg.sv */
// Types of the on/off delay timer.
// Assumes oodt_map.svh holds the numbers.
package oodt_pkg;

  typedef enum logic [2:0] {
    oodt_idle = 3'h1,
    oodt_hold = 3'h2,
    oodt_time = 3'h4
  } oodt_state_t;

  typedef enum logic [1:0] {
    oodt_tb_fine = 2'h0,
    oodt_tb_sec  = 2'h1,
    oodt_tb_min  = 2'h2
  } oodt_tb_t;

endpackage

/* core/oodt_tick_gen.sv */
// Time-base tick generator: 10 ms, 1 s and 1 min pulses.
// Assumes a free clock; restart_i realigns all prescalers.
`timescale 1ns/1ps
`include "oodt_map.svh"
module oodt_tick_gen
  import oodt_pkg::*;
#(
  parameter int unsigned CYC_FINE     = `OODT_CYC_FINE,
  parameter int unsigned FINE_PER_SEC = `OODT_FINE_PER_SEC,
  parameter int unsigned SEC_PER_MIN  = `OODT_SEC_PER_MIN
) (
  // Clock and control
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       restart_i,
  // Ticks, index by oodt_tb_t
  output logic [2:0]      tick_o
);

  localparam int FW = (CYC_FINE > 2) ? $clog2(CYC_FINE) : 1;

  // Second and minute prescalers are 7 and 6 bits wide
  if (CYC_FINE < 2 || FINE_PER_SEC < 2 || SEC_PER_MIN < 2 ||
      FINE_PER_SEC > 128 || SEC_PER_MIN > 64) begin : g_bad
    $error("oodt_tick_gen: prescale counts out of range");
  end

  logic [FW-1:0] cnt_fine;
  logic [6:0]    cnt_sec;
  logic [5:0]    cnt_min;

  wire wrap_fine = (cnt_fine == FW'(CYC_FINE - 1));
  wire wrap_sec  = wrap_fine & (cnt_sec == 7'(FINE_PER_SEC - 1));
  wire wrap_min  = wrap_sec & (cnt_min == 6'(SEC_PER_MIN - 1));

  // Prescaler chain; restart keeps the first tick a full period away
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_fine <= '0;
      cnt_sec  <= '0;
      cnt_min  <= '0;
      tick_o   <= '0;
    end else if (ce_i) begin
      if (restart_i) begin
        cnt_fine <= '0;
        cnt_sec  <= '0;
        cnt_min  <= '0;
        tick_o   <= '0;
      end else begin
        cnt_fine <= wrap_fine ? '0 : cnt_fine + 1'b1;
        if (wrap_fine) cnt_sec <= wrap_sec ? '0 : cnt_sec + 1'b1;
        if (wrap_sec)  cnt_min <= wrap_min ? '0 : cnt_min + 1'b1;
        tick_o   <= {wrap_min, wrap_sec, wrap_fine};
      end
    end
  end

endmodule // oodt_tick_gen

/* core/oodt_timer.sv */
// On-delay / off-delay relay timer with an Avalon-MM register port.
// Assumes trigger, clear and block values come from logic on clock_i.
`timescale 1ns/1ps
`include "oodt_map.svh"
module oodt_timer
  import oodt_pkg::*;
#(
  parameter int unsigned CYC_FINE = `OODT_CYC_FINE,
  parameter int unsigned NUM_SRC  = 16,
  parameter int unsigned SRC_W    = 17
) (
  // Clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  // Avalon-MM slave
  input  wire logic [4:0]               avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [31:0]              avs_writedata_i,
  input  wire logic [3:0]               avs_byteenable_i,
  output logic      [31:0]              avs_readdata_o,
  output logic                          avs_waitrequest_o,
  // Function block inputs
  input  wire logic                     trg_i,
  input  wire logic                     clr_i,
  input  wire logic                     power_up_i,
  input  wire logic [NUM_SRC*SRC_W-1:0] src_values_i,
  // Relay output
  output logic                          relay_o
);

  if (NUM_SRC < 1 || NUM_SRC > 16 || SRC_W < 17) begin : g_bad
    $error("oodt_timer: NUM_SRC must be 1..16 and SRC_W at least 17");
  end

  ////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic hit(input logic [4:0] a,
                               input logic [4:0] ofs);
    return {a[4:2], 2'b00} == ofs;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers and state

  logic [31:0]  ctrl;
  logic [31:0]  delay_reg;
  oodt_state_t  state;
  oodt_state_t  next_state;
  logic [13:0]  elapsed_time;
  logic [13:0]  next_elapsed;
  logic         relay_q;
  logic         next_q;
  logic         trig_q;
  logic         restart;
  logic [2:0]   ticks;

  ////////////////////////////////////////////////////////////////////
  // Configuration fields

  wire       mode_off = ctrl[`OODT_CTRL_MODE_BIT];
  wire [1:0] tb_raw   = ctrl[`OODT_CTRL_TB_LSB +: 2];
  wire       src_sel  = ctrl[`OODT_CTRL_SRC_BIT];
  wire       retain   = ctrl[`OODT_CTRL_RET_BIT];
  wire [3:0] blk      = ctrl[`OODT_CTRL_BLK_LSB +: 4];

  // Unused base code behaves as minutes
  wire [1:0] tb      = (tb_raw == 2'h3) ? oodt_tb_min : tb_raw;
  wire       tb_fine = (tb == oodt_tb_fine);

  ////////////////////////////////////////////////////////////////////
  // Constant delay in ticks

  wire [6:0] maj_raw = delay_reg[`OODT_DLY_MAJ_LSB +: 7];
  wire [6:0] min_raw = delay_reg[`OODT_DLY_MIN_LSB +: 7];
  wire [6:0] maj_c   = (maj_raw > `OODT_MAX_MAJOR) ? `OODT_MAX_MAJOR
                                                   : maj_raw;
  wire [6:0] min_lim = tb_fine ? `OODT_MAX_MINOR_FINE
                               : `OODT_MAX_MINOR_60;
  wire [6:0] min_c   = (min_raw > min_lim) ? min_lim : min_raw;

  // ss:cc, mm:ss or hh:mm folded into fine, second or minute ticks
  wire [13:0] scale      = tb_fine ? 14'(`OODT_FINE_PER_SEC)
                                   : 14'(`OODT_SEC_PER_MIN);
  wire [13:0] const_tick = 14'(maj_c) * scale + 14'(min_c);

  ////////////////////////////////////////////////////////////////////
  // Delay from another block's value

  wire [3:0]       blk_ok  = (32'(blk) < NUM_SRC) ? blk : 4'h0;
  wire [SRC_W-1:0] src_raw = src_values_i[32'(blk_ok)*SRC_W +: SRC_W];
  wire [SRC_W-1:0] src_lim = tb_fine ? SRC_W'(`OODT_MAX_SRC_MS)
                                     : SRC_W'(`OODT_MAX_SRC_UNIT);
  wire [SRC_W-1:0] src_c   = (src_raw > src_lim) ? src_lim
                                                 : src_raw;
  // Milliseconds counted in 10 ms ticks, rounded down
  wire [SRC_W-1:0] src_div = src_c / SRC_W'(`OODT_MS_PER_FINE);
  wire [13:0]      src_tick = tb_fine ? src_div[13:0]
                                      : src_c[13:0];

  wire [13:0] delay_ticks = src_sel ? src_tick
                                    : const_tick;

  ////////////////////////////////////////////////////////////////////
  // Time base

  oodt_tick_gen #(
    .CYC_FINE     (CYC_FINE),
    .FINE_PER_SEC (`OODT_FINE_PER_SEC),
    .SEC_PER_MIN  (`OODT_SEC_PER_MIN)
  ) u_tick (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .restart_i (restart),
    .tick_o    (ticks)
  );

  wire tick_sel = ticks[tb];

  ////////////////////////////////////////////////////////////////////
  // Trigger edges

  wire rise     = trg_i & ~trig_q;
  wire pwr_kill = power_up_i & ~retain;
  wire reached  = (elapsed_time >= delay_ticks);

  ////////////////////////////////////////////////////////////////////
  // Delay state machine

  always_comb begin
    next_state   = state;
    next_elapsed = elapsed_time;
    next_q       = relay_q;
    restart      = 1'b0;
    if (pwr_kill) begin
      next_state   = oodt_idle;
      next_elapsed = '0;
      next_q       = 1'b0;
    end else if (mode_off && clr_i) begin
      next_state   = oodt_idle;
      next_elapsed = '0;
      next_q       = 1'b0;
    end else begin
      unique case (state)
        oodt_idle: begin
          if (rise) begin
            next_state   = mode_off ? oodt_hold : oodt_time;
            next_elapsed = '0;
            next_q       = mode_off;
            restart      = ~mode_off;
          end
        end
        oodt_hold: begin
          if (!trg_i && mode_off) begin
            next_state   = oodt_time;
            next_elapsed = '0;
            restart      = 1'b1;
          end else if (!trg_i) begin
            next_state   = oodt_idle;
            next_elapsed = '0;
            next_q       = 1'b0;
          end
        end
        oodt_time: begin
          if (mode_off) begin
            if (trg_i) begin
              next_state   = oodt_hold;
              next_elapsed = '0;
              next_q       = 1'b1;
            end else if (reached) begin
              next_state = oodt_idle;
              next_q     = 1'b0;
            end else if (tick_sel) begin
              next_elapsed = elapsed_time + 14'h1;
            end
          end else begin
            if (!trg_i) begin
              next_state   = oodt_idle;
              next_elapsed = '0;
              next_q       = 1'b0;
            end else if (reached) begin
              next_state = oodt_hold;
              next_q     = 1'b1;
            end else if (tick_sel) begin
              next_elapsed = elapsed_time + 14'h1;
            end
          end
        end
        default: begin
          next_state   = oodt_idle;
          next_elapsed = '0;
          next_q       = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state        <= oodt_idle;
      elapsed_time <= '0;
      relay_q      <= 1'b0;
      trig_q       <= 1'b0;
    end else if (ce_i) begin
      state        <= next_state;
      elapsed_time <= next_elapsed;
      relay_q      <= next_q;
      trig_q       <= trg_i;
    end
  end

  assign relay_o = relay_q;

  ////////////////////////////////////////////////////////////////////
  // Register port

  wire bus_take  = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  wire wr_commit = avs_write_i & ~avs_waitrequest_o;

  wire sel_ctrl  = hit(avs_address_i, `OODT_CTRL_OFS);
  wire sel_dly   = hit(avs_address_i, `OODT_DELAY_OFS);
  wire sel_stat  = hit(avs_address_i, `OODT_STATUS_OFS);
  wire sel_elap  = hit(avs_address_i, `OODT_ELAPSED_OFS);

  wire [31:0] status_word = (32'(delay_ticks) << `OODT_STAT_DLY_LSB)
                          | (32'(state == oodt_time) << `OODT_STAT_RUN_BIT)
                          | (32'(trg_i) << `OODT_STAT_TRG_BIT)
                          | (32'(relay_q) << `OODT_STAT_Q_BIT);

  wire [31:0] rd_word = sel_ctrl ? ctrl
                      : sel_dly  ? delay_reg
                      : sel_stat ? status_word
                      : sel_elap ? 32'(elapsed_time)
                      : 32'h0;

  // One wait cycle per access; read data lands as waitrequest drops, the write one edge later
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
      ctrl              <= `OODT_CTRL_RST;
      delay_reg         <= `OODT_DLY_RST;
    end else if (ce_i) begin
      avs_waitrequest_o <= ~bus_take;
      if (bus_take && avs_read_i) avs_readdata_o <= rd_word;
      if (wr_commit && sel_ctrl)
        ctrl <= merge(ctrl, avs_writedata_i, avs_byteenable_i)
                & `OODT_CTRL_MASK;
      if (wr_commit && sel_dly)
        delay_reg <= merge(delay_reg, avs_writedata_i, avs_byteenable_i)
                     & `OODT_DLY_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_on(cond);
    ce_i && !mode_off && !pwr_kill && cond;
  endsequence

  sequence s_off(cond);
    ce_i && mode_off && !clr_i && !pwr_kill && cond;
  endsequence

  sequence s_off_fall;
    s_off(state == oodt_hold && trg_i) ##1
    s_off(state == oodt_hold && !trg_i);
  endsequence

  a_on_rise_zero: assert property (
    s_on(rise && state == oodt_idle) |=> elapsed_time == 14'h0
                                         && state == oodt_time)
    else $error("on-delay rise did not start from zero");

  a_on_set_late: assert property (
    s_on(state == oodt_time && trg_i && reached) |=> relay_q)
    else $error("on-delay output not set after delay");

  a_on_no_early: assert property (
    !mode_off && !$past(mode_off) && $rose(relay_q)
      |-> $past(elapsed_time) >= $past(delay_ticks))
    else $error("on-delay output set before delay");

  a_on_short_pulse: assert property (
    s_on(state == oodt_time && !trg_i)
      |=> elapsed_time == 14'h0 && !relay_q)
    else $error("short trigger left elapsed time or output");

  a_on_low_trig: assert property (
    s_on(!trg_i) |=> !relay_q)
    else $error("on-delay output high with trigger low");

  a_off_rise_set: assert property (
    s_off(rise) |=> relay_q)
    else $error("off-delay rise did not set output");

  a_off_fall_hold: assert property (
    s_off_fall |=> relay_q && elapsed_time == 14'h0
                   && state == oodt_time)
    else $error("off-delay fall did not restart with output held");

  a_off_expire: assert property (
    s_off(state == oodt_time && !trg_i && reached) |=> !relay_q)
    else $error("off-delay output not cleared at delay");

  a_off_retrig: assert property (
    s_off(state == oodt_time && trg_i)
      |=> relay_q && elapsed_time == 14'h0)
    else $error("off-delay retrigger did not restart");

  a_clear_wins: assert property (
    ce_i && mode_off && clr_i |=> !relay_q && elapsed_time == 14'h0)
    else $error("clear did not win over trigger");

  a_power_clear: assert property (
    ce_i && pwr_kill |=> !relay_q && elapsed_time == 14'h0)
    else $error("state kept over power loss without retention");

  a_tick_count: assert property (
    s_on(state == oodt_time && trg_i && !reached && tick_sel)
      |=> elapsed_time == $past(elapsed_time) + 14'h1)
    else $error("elapsed time did not advance on tick");

  a_edge_detect: assert property (
    (ce_i && !trg_i) ##1 trg_i |-> rise)
    else $error("trigger rise not detected");

endmodule // oodt_timer

/* dv/oodt_fb_model.sv */
// Model of the function blocks wired to the timer: trigger, clear, block values.
// Assumes the bench calls set_in; inputs change only right after a rising edge.
`timescale 1ns/1ps
module oodt_fb_model #(
  parameter int unsigned NUM_SRC = 16,
  parameter int unsigned SRC_W   = 17
) (
  // Clock
  input  wire logic                     clock_i,
  // Drives of the timer block
  output logic                          trg_o,
  output logic                          clr_o,
  output logic [NUM_SRC*SRC_W-1:0]      src_values_o
);
  initial begin
    trg_o = 1'b0;
    clr_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Block k holds k*10+5; block 5 holds 9000, above the 5999 s/min limit
  for (genvar k = 0; k < NUM_SRC; k++) begin : g_src
    assign src_values_o[k*SRC_W +: SRC_W] = (k == 5) ? SRC_W'(17'h02328)
                                                     : SRC_W'(k * 10 + 5);
  end

  ////////////////////////////////////////////////////////////////////////////
  // New trigger and clear levels, launched just after an edge
  task automatic set_in(input logic t, input logic c);
    @(posedge clock_i);
    trg_o <= t;
    clr_o <= c;
  endtask
endmodule // oodt_fb_model

/* dv/tb.sv */
// Self-checking bench of the on/off delay timer.
// Assumes CYC_FINE of 4 cycles and the register map of oodt_map.svh.
`timescale 1ns/1ps
`include "oodt_map.svh"
module tb;
  import oodt_pkg::*;
  logic             clock_i;
  logic             rst_i;
  logic             power_up_i;
  logic [4:0]       avs_address_i;
  logic             avs_read_i;
  logic             avs_write_i;
  logic [31:0]      avs_writedata_i;
  logic [31:0]      avs_readdata_o;
  logic             avs_waitrequest_o;
  logic             relay_o;
  logic             trg;
  logic             clr;
  logic [16*17-1:0] src;
  logic             ce;
  logic [3:0]       be;
  int               n_fail;
  int               check_count;

  oodt_fb_model oodt_fb_model_inst (
    .clock_i(clock_i), .trg_o(trg), .clr_o(clr), .src_values_o(src));
  oodt_timer #(.CYC_FINE(4)) oodt_timer_inst (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(be), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .trg_i(trg), .clr_i(clr),
    .power_up_i(power_up_i), .src_values_i(src), .relay_o(relay_o));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, exp, q);
  endtask

  // Relay reaches v within n edges
  task automatic q_wait(input string nm, input logic v, input int n);
    int i;
    i = 0;
    while (relay_o !== v && i < n) begin
      @(posedge clock_i);
      i++;
    end
    chk(nm, {31'h0, v}, {31'h0, relay_o});
  endtask

  // Relay keeps v over n edges
  task automatic q_stay(input string nm, input logic v, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge clock_i);
      if (relay_o !== v) bad++;
    end
    chk(nm, 32'h0, bad);
  endtask

  task automatic pwr();
    @(posedge clock_i);
    power_up_i <= 1'b1;
    @(posedge clock_i);
    power_up_i <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    end_of_test();
  end

  // Control, delay, expected effective delay in ticks
  logic [31:0] tab [6][3] = '{
    '{32'h0, 32'h6378, 32'h270f}, '{32'h2, 32'h0246, 32'hb3}, '{32'h4, 32'h0246, 32'hb3},
    '{32'h208, 32'h0, 32'h2}, '{32'h50a, 32'h0, 32'h176f}, '{32'h50c, 32'h0, 32'h176f}};

  initial begin
    n_fail = 0;
    check_count = 0;
    rst_i = 1'b1;
    power_up_i = 1'b0;
    avs_address_i = 5'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    ce = 1'b1;
    be = 4'hf;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    chk("relay reset", 32'h0, {31'h0, relay_o});
    rd("ctrl reset", `OODT_CTRL_OFS, `OODT_CTRL_RST);
    rd("delay reset", `OODT_DELAY_OFS, `OODT_DLY_RST);
    rd("unmapped", 5'h10, 32'h0);
    wr(`OODT_CTRL_OFS, 32'hffffffff);
    rd("ctrl mask", `OODT_CTRL_OFS, `OODT_CTRL_MASK);
    wr(`OODT_ELAPSED_OFS, 32'hffffffff);
    rd("elapsed ro", `OODT_ELAPSED_OFS, 32'h0);
    wr(`OODT_DELAY_OFS, 32'h00000505);
    // Only byte lane 1 may land
    be <= 4'h2;
    wr(`OODT_DELAY_OFS, 32'h00007f7f);
    be <= 4'hf;
    rd("delay lanes", `OODT_DELAY_OFS, 32'h00007f05);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      wr(`OODT_CTRL_OFS, tab[i][0]);
      wr(`OODT_DELAY_OFS, tab[i][1]);
      rd("eff delay", `OODT_STATUS_OFS, {2'h0, tab[i][2][13:0], 16'h0});
    end
    $display("test delay source done");
    wr(`OODT_CTRL_OFS, 32'h0);
    wr(`OODT_DELAY_OFS, 32'h3);
    oodt_fb_model_inst.set_in(1'b1, 1'b0);
    q_stay("on wait", 1'b0, 11);
    q_wait("on set", 1'b1, 8);
    rd("status on", `OODT_STATUS_OFS, 32'h00030003);
    oodt_fb_model_inst.set_in(1'b0, 1'b0);
    q_wait("on low", 1'b0, 2);
    oodt_fb_model_inst.set_in(1'b1, 1'b0);
    repeat (8) @(posedge clock_i);
    oodt_fb_model_inst.set_in(1'b0, 1'b0);
    q_stay("on abort", 1'b0, 20);
    rd("on abort elapsed", `OODT_ELAPSED_OFS, 32'h0);
    $display("test on-delay done");
    wr(`OODT_CTRL_OFS, 32'h1);
    oodt_fb_model_inst.set_in(1'b1, 1'b0);
    q_wait("off set", 1'b1, 2);
    oodt_fb_model_inst.set_in(1'b0, 1'b0);
    q_stay("off hold", 1'b1, 11);
    q_wait("off expire", 1'b0, 8);
    oodt_fb_model_inst.set_in(1'b1, 1'b0);
    oodt_fb_model_inst.set_in(1'b0, 1'b0);
    q_stay("retrig a", 1'b1, 8);
    oodt_fb_model_inst.set_in(1'b1, 1'b0);
    oodt_fb_model_inst.set_in(1'b0, 1'b0);
    q_stay("retrig b", 1'b1, 11);
    q_wait("retrig end", 1'b0, 8);
    oodt_fb_model_inst.set_in(1'b1, 1'b0);
    q_wait("clr pre", 1'b1, 3);
    oodt_fb_model_inst.set_in(1'b1, 1'b1);
    q_wait("clr wins", 1'b0, 3);
    oodt_fb_model_inst.set_in(1'b1, 1'b0);
    q_stay("clr no rise", 1'b0, 6);
    rd("clr elapsed", `OODT_ELAPSED_OFS, 32'h0);
    oodt_fb_model_inst.set_in(1'b0, 1'b0);
    $display("test off-delay done");
    wr(`OODT_DELAY_OFS, 32'h0100);
    wr(`OODT_CTRL_OFS, 32'h11);
    oodt_fb_model_inst.set_in(1'b1, 1'b0);
    q_wait("ret set", 1'b1, 3);
    oodt_fb_model_inst.set_in(1'b0, 1'b0);
    pwr();
    q_stay("ret kept", 1'b1, 4);
    rd("status run", `OODT_STATUS_OFS, 32'h00640005);
    wr(`OODT_CTRL_OFS, 32'h1);
    pwr();
    q_wait("ret off", 1'b0, 3);
    $display("test retention done");
    wr(`OODT_CTRL_OFS, 32'h2);
    wr(`OODT_DELAY_OFS, 32'h1);
    oodt_fb_model_inst.set_in(1'b1, 1'b0);
    q_stay("sec wait", 1'b0, 390);
    q_wait("sec set", 1'b1, 20);
    oodt_fb_model_inst.set_in(1'b0, 1'b0);
    // Enable low freezes the relay despite trigger low
    ce <= 1'b0;
    q_stay("ce frozen", 1'b1, 5);
    ce <= 1'b1;
    q_wait("ce run", 1'b0, 3);
    $display("test second base done");
    end_of_test();
  end
endmodule // tb
